/* File: logic/bt_base_timer.sv */
// Base timer: 8-bit period match or 16-bit free-running counter.
// Assumes software strobes are one-cycle pulses synchronous to sys_clk_i.
//
// What this block does
// - Width bit picks 8-bit or 16-bit mode
// - Count advances once per prescaled clock edge
// - Prescaler between source and counter, selectable ratio
// - 8-bit: compare low byte with buffered period
// - Match clears low byte, reloads period buffer
// - 16-bit: low read latches upper byte
// - 16-bit: high write buffered, applied on low write
// - 16-bit: count wraps from all ones to zero
// - 16-bit: no automatic reload once running
// - 3-bit field selects count clock source
// - Prescaled clock used synchronised or asynchronous
`timescale 1ns/1ps
`default_nettype none
module bt_base_timer
	import bt_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	// Count clock sources
	input  wire logic                 logic_cell1_output_i,
	input  wire logic                 secondary_oscillator_i,
	input  wire logic                 medium_freq_internal_osc_i,
	input  wire logic                 low_freq_internal_osc_i,
	input  wire logic                 high_freq_internal_osc_i,
	input  wire logic                 instruction_clock_i,
	// Configuration
	input  wire logic                 counter_width_select_i,
	input  wire logic [BT_CS_W-1:0]   clock_source_select_i,
	input  wire logic [BT_PS_W-1:0]   prescale_select_i,
	input  wire logic                 async_select_i,
	// Software access strobes
	input  wire logic                 low_byte_rd_i,
	input  wire logic                 low_byte_wr_i,
	input  wire logic                 high_byte_wr_i,
	input  wire logic [BT_BYTE_W-1:0] wr_data_i,
	input  wire logic                 overflow_clr_i,
	// Visible state
	output logic [BT_BYTE_W-1:0]      count_low_byte_o,
	output logic [BT_BYTE_W-1:0]      count_high_byte_o,
	output logic                      overflow_flag_o
);
	logic                 tick;         // Prescaled count edge
	logic [BT_BYTE_W-1:0] cnt_upper_ff; // Counter upper byte, 16-bit mode
	logic [BT_BYTE_W-1:0] period_buf_ff;// Period copy used for compare
	logic                 match;        // 8-bit compare hit
	logic                 wrap;         // 16-bit rollover
	logic                 wide;         // 16-bit mode
	logic                 carry;        // Low byte rolls into the upper byte

	// All-ones test on a count byte; shared by the carry and wrap terms
	function automatic logic byte_full(input logic [BT_BYTE_W-1:0] b);
		byte_full = (b == BT_BYTE_ONES);
	endfunction

	// Mode and event decode; carry and wrap only exist in 16-bit mode
	assign wide  = counter_width_select_i;
	assign match = tick && !wide && (count_low_byte_o == period_buf_ff);
	assign carry = tick && wide && byte_full(count_low_byte_o);
	assign wrap  = carry && byte_full(cnt_upper_ff);

	// Clock selection, prescaler and sync option
	bt_clock_front u_front (
		.sys_clk_i                  (sys_clk_i),
		.rst_n_i                    (rst_n_i),
		.logic_cell1_output_i       (logic_cell1_output_i),
		.secondary_oscillator_i     (secondary_oscillator_i),
		.medium_freq_internal_osc_i (medium_freq_internal_osc_i),
		.low_freq_internal_osc_i    (low_freq_internal_osc_i),
		.high_freq_internal_osc_i   (high_freq_internal_osc_i),
		.instruction_clock_i        (instruction_clock_i),
		.clock_source_select_i      (clock_source_select_i),
		.prescale_select_i          (prescale_select_i),
		.async_select_i             (async_select_i),
		.count_tick_o               (tick)
	);

	// Low byte: software write beats a tick in the same cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_low_byte_o <= BT_BYTE_ZERO;
		else if (low_byte_wr_i)
			count_low_byte_o <= wr_data_i;
		else if (match)
			count_low_byte_o <= BT_BYTE_ZERO;
		else if (tick)
			count_low_byte_o <= count_low_byte_o + BT_BYTE_ONE;
	end

	// Upper counter byte, only moves in 16-bit mode
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_upper_ff <= BT_BYTE_ZERO;
		else if (wide && low_byte_wr_i)
			cnt_upper_ff <= count_high_byte_o;
		else if (carry)
			cnt_upper_ff <= cnt_upper_ff + BT_BYTE_ONE;
	end

	// High byte register: write buffer, read latch in 16-bit mode
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_high_byte_o <= BT_BYTE_ONES;
		else if (high_byte_wr_i)
			count_high_byte_o <= wr_data_i;
		else if (wide && low_byte_rd_i)
			count_high_byte_o <= cnt_upper_ff;
	end

	// Period buffer: only refreshed on a match, so writes take effect next period
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			period_buf_ff <= BT_BYTE_ONES;
		else if (match)
			period_buf_ff <= count_high_byte_o;
	end

	// Overflow flag: a new event wins over a clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			overflow_flag_o <= 1'b0;
		else if (match || wrap)
			overflow_flag_o <= 1'b1;
		else if (overflow_clr_i)
			overflow_flag_o <= 1'b0;
	end

	// Checks: 8-bit mode
	a_match_clears_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		match && !low_byte_wr_i |=> count_low_byte_o == BT_BYTE_ZERO)
		else $error("low byte not cleared on match");
	a_match_reloads_buf: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		match |=> period_buf_ff == $past(count_high_byte_o))
		else $error("period buffer not reloaded");
	a_narrow_increment: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		tick && !wide && !match && !low_byte_wr_i
		|=> count_low_byte_o == $past(count_low_byte_o) + BT_BYTE_ONE)
		else $error("8-bit count did not advance");
	// Upper byte stays frozen while in 8-bit mode
	a_upper_hold_narrow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!wide |=> $stable(cnt_upper_ff))
		else $error("upper byte moved in 8-bit mode");
	// A new period waits for the next match, never applied mid-period
	a_buf_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!match |=> $stable(period_buf_ff))
		else $error("period buffer moved without match");

	// Checks: 16-bit mode
	// Every tick without a low byte write advances the low byte, all-ones included
	a_wide_increment: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		tick && wide && !low_byte_wr_i
		|=> count_low_byte_o == $past(count_low_byte_o) + BT_BYTE_ONE)
		else $error("16-bit low byte did not advance");
	// A low byte rollover carries into the upper byte
	a_wide_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		carry && !low_byte_wr_i |=> cnt_upper_ff == $past(cnt_upper_ff) + BT_BYTE_ONE)
		else $error("carry into upper byte lost");
	// Upper byte only moves by carry or by a low byte write
	a_upper_no_reload: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wide && !carry && !low_byte_wr_i |=> $stable(cnt_upper_ff))
		else $error("upper byte reloaded");
	a_wide_wrap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wrap && !low_byte_wr_i |=> count_low_byte_o == BT_BYTE_ZERO
		&& cnt_upper_ff == BT_BYTE_ZERO && overflow_flag_o)
		else $error("16-bit wrap wrong");
	a_read_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wide && low_byte_rd_i && !high_byte_wr_i |=> count_high_byte_o == $past(cnt_upper_ff))
		else $error("upper byte not latched on read");
	a_write_transfer: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wide && low_byte_wr_i |=> cnt_upper_ff == $past(count_high_byte_o)
		&& count_low_byte_o == $past(wr_data_i))
		else $error("buffered high byte not applied");
	// High byte write lands in the register on its own
	a_high_write_take: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		high_byte_wr_i |=> count_high_byte_o == $past(wr_data_i))
		else $error("high byte write lost");
	// High register only moves by a write or a 16-bit low read
	a_high_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!high_byte_wr_i && !(wide && low_byte_rd_i) |=> $stable(count_high_byte_o))
		else $error("high byte moved unasked");
	a_no_tick_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!tick && !low_byte_wr_i |=> $stable(count_low_byte_o))
		else $error("count moved without tick");

	// Checks: overflow flag
	a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		overflow_flag_o && !overflow_clr_i |=> overflow_flag_o [*1])
		else $error("overflow flag dropped");
	a_flag_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(match || wrap) && overflow_clr_i |=> overflow_flag_o)
		else $error("clear beat a new event");
	// Clear without a competing event drops the flag
	a_flag_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		overflow_clr_i && !match && !wrap |=> !overflow_flag_o)
		else $error("overflow flag not cleared");
	// Flag rises only on a match or a wrap
	a_flag_no_spurious: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!overflow_flag_o && !match && !wrap |=> !overflow_flag_o)
		else $error("overflow flag set without event");

	// Coverage of main scenarios
	c_narrow_match: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) match);
	c_wide_wrap:    cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) wrap);
	c_read_then_write: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wide && low_byte_rd_i ##[1:20] wide && low_byte_wr_i);
	c_set_and_clear: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(match || wrap) && overflow_clr_i);
	c_buffered_write: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wide && high_byte_wr_i ##[1:20] wide && low_byte_wr_i);

endmodule // bt_base_timer
`default_nettype wire

/* File: logic/bt_clock_front.sv */
// Count clock front end: source select, edge detect, prescaler, sync option.
// Assumes all source levels are already synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module bt_clock_front
	import bt_pkg::*;
(
	// Clock and reset
	input  wire logic                sys_clk_i,
	input  wire logic                rst_n_i,
	// Source levels
	input  wire logic                logic_cell1_output_i,
	input  wire logic                secondary_oscillator_i,
	input  wire logic                medium_freq_internal_osc_i,
	input  wire logic                low_freq_internal_osc_i,
	input  wire logic                high_freq_internal_osc_i,
	input  wire logic                instruction_clock_i,
	// Configuration
	input  wire logic [BT_CS_W-1:0]  clock_source_select_i,
	input  wire logic [BT_PS_W-1:0]  prescale_select_i,
	input  wire logic                async_select_i,
	// Prescaled count tick
	output logic                     count_tick_o
);
	logic                reserved;      // Codes without a source
	logic                src_level;     // Selected source level
	logic                src_prev_ff;   // Last source level
	logic                ic_prev_ff;    // Last instruction clock level
	logic                ic_rise;       // Instruction clock edge
	logic                src_rise;      // Source rising edge
	logic [BT_PSC_W-1:0] psc_cnt_ff;    // Prescale counter
	logic                psc_out;       // Prescaled edge, unsynchronised
	logic                pending_ff;    // Edge waiting for instruction clock
	logic                nxt_tick;

	// Ratio mask: 2^sel - 1
	function automatic logic [BT_PSC_W-1:0] psc_mask(input logic [BT_PS_W-1:0] sel);
		psc_mask = (BT_PSC_ONE << sel) - BT_PSC_ONE;
	endfunction

	// Source multiplexer
	always_comb
	begin
		reserved  = 1'b0;
		src_level = 1'b0;
		case (clock_source_select_i)
			BT_CS_LOGIC_CELL1: src_level = logic_cell1_output_i;
			BT_CS_SECONDARY:   src_level = secondary_oscillator_i;
			BT_CS_MEDIUM_OSC:  src_level = medium_freq_internal_osc_i;
			BT_CS_LOW_OSC:     src_level = low_freq_internal_osc_i;
			BT_CS_HIGH_OSC:    src_level = high_freq_internal_osc_i;
			BT_CS_INSTR_CLK:   src_level = instruction_clock_i;
			default:           reserved  = 1'b1;
		endcase
	end

	assign src_rise = src_level & ~src_prev_ff;
	assign ic_rise  = instruction_clock_i & ~ic_prev_ff;
	assign psc_out  = src_rise && (psc_cnt_ff >= psc_mask(prescale_select_i));

	// Edge history
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			src_prev_ff <= 1'b0;
			ic_prev_ff  <= 1'b0;
		end
		else
		begin
			src_prev_ff <= src_level;
			ic_prev_ff  <= instruction_clock_i;
		end
	end

	// Prescaler; a count left above a lowered ratio fires on the next edge,
	// so it never has to run on to its own rollover before counting again
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			psc_cnt_ff <= BT_PSC_ZERO;
		else if (reserved)
			psc_cnt_ff <= BT_PSC_ZERO;
		else if (psc_out)
			psc_cnt_ff <= BT_PSC_ZERO;
		else if (src_rise)
			psc_cnt_ff <= psc_cnt_ff + BT_PSC_ONE;
	end

	// Sync option: hold the edge until the instruction clock rises
	always_comb
	begin
		if (reserved)
			nxt_tick = 1'b0;
		else if (async_select_i)
			nxt_tick = psc_out;
		else
			nxt_tick = (pending_ff | psc_out) & ic_rise;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pending_ff <= 1'b0;
		else if (reserved || async_select_i)
			pending_ff <= 1'b0;
		else if (ic_rise)
			pending_ff <= 1'b0;
		else if (psc_out)
			pending_ff <= 1'b1;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_tick_o <= 1'b0;
		else
			count_tick_o <= nxt_tick;
	end

	a_reserved_no_tick: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reserved |=> !count_tick_o) else $error("tick on reserved source");

endmodule // bt_clock_front
`default_nettype wire

/* File: logic/bt_pkg.sv */
// Constants shared by the base timer and its clock front end.
// Assumes every user of it imports the whole package.
`default_nettype none
package bt_pkg;
	// Field widths
	localparam int unsigned BT_BYTE_W = 8;
	localparam int unsigned BT_CS_W   = 3;
	localparam int unsigned BT_PS_W   = 4;
	localparam int unsigned BT_PSC_W  = 16;
	// Clock source codes
	localparam logic [2:0] BT_CS_LOGIC_CELL1 = 3'h7;
	localparam logic [2:0] BT_CS_SECONDARY   = 3'h6;
	localparam logic [2:0] BT_CS_MEDIUM_OSC  = 3'h5;
	localparam logic [2:0] BT_CS_LOW_OSC     = 3'h4;
	localparam logic [2:0] BT_CS_HIGH_OSC    = 3'h3;
	localparam logic [2:0] BT_CS_INSTR_CLK   = 3'h2;
	// Reset and special values
	localparam logic [7:0]  BT_BYTE_ZERO = 8'h00;
	localparam logic [7:0]  BT_BYTE_ONE  = 8'h01;
	localparam logic [7:0]  BT_BYTE_ONES = 8'hFF;
	localparam logic [15:0] BT_PSC_ZERO  = 16'h0000;
	localparam logic [15:0] BT_PSC_ONE   = 16'h0001;
endpackage : bt_pkg
`default_nettype wire

/* File: tb/bt_base_timer_tb.sv */
// Self-checking bench for the base timer: both widths, prescaler, sources, sync.
// Assumes the bt_pkg package and the bt_base_timer design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bt_pkg::*;

	// Compare two values and count the outcome
	`define BT_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
		$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end

	// Clock, reset and stimulus
	logic                 sys_clk_i      = 1'b0;
	logic                 rst_n_i        = 1'b0;
	logic [5:0]           src_lvl        = 6'h00; // Bit i feeds source code i+2
	logic                 width_sel      = 1'b0;
	logic [BT_CS_W-1:0]   cs_sel         = BT_CS_INSTR_CLK;
	logic [BT_PS_W-1:0]   ps_sel         = 4'h0;
	logic                 async_sel      = 1'b1;
	logic                 low_byte_rd_i  = 1'b0;
	logic                 low_byte_wr_i  = 1'b0;
	logic                 high_byte_wr_i = 1'b0;
	logic [BT_BYTE_W-1:0] wr_data_i      = 8'h00;
	logic                 overflow_clr_i = 1'b0;
	// Observed outputs
	logic [BT_BYTE_W-1:0] count_low_byte_o;
	logic [BT_BYTE_W-1:0] count_high_byte_o;
	logic                 overflow_flag_o;
	// Scoreboard: each note is {mask, expected} over {flag, high, low}
	logic [33:0]          exp_q[$];
	logic                 chk_req        = 1'b0;
	int                   err_total      = 0;
	int                   check_count    = 0;
	int                   k;

	// Free running 250 MHz clock
	always #2 sys_clk_i = ~sys_clk_i;

	bt_base_timer i_dut (
		.sys_clk_i                  (sys_clk_i),
		.rst_n_i                    (rst_n_i),
		.logic_cell1_output_i       (src_lvl[5]),
		.secondary_oscillator_i     (src_lvl[4]),
		.medium_freq_internal_osc_i (src_lvl[3]),
		.low_freq_internal_osc_i    (src_lvl[2]),
		.high_freq_internal_osc_i   (src_lvl[1]),
		.instruction_clock_i        (src_lvl[0]),
		.counter_width_select_i     (width_sel),
		.clock_source_select_i      (cs_sel),
		.prescale_select_i          (ps_sel),
		.async_select_i             (async_sel),
		.low_byte_rd_i              (low_byte_rd_i),
		.low_byte_wr_i              (low_byte_wr_i),
		.high_byte_wr_i             (high_byte_wr_i),
		.wr_data_i                  (wr_data_i),
		.overflow_clr_i             (overflow_clr_i),
		.count_low_byte_o           (count_low_byte_o),
		.count_high_byte_o          (count_high_byte_o),
		.overflow_flag_o            (overflow_flag_o)
	);

	// Monitor: mid-cycle, outputs are settled, so take the oldest note
	always @(negedge sys_clk_i)
	begin
		logic [33:0] n;
		if (chk_req === 1'b1)
		begin
			n = exp_q.pop_front();
			`BT_CHK({overflow_flag_o, count_high_byte_o, count_low_byte_o} & n[33:17], n[16:0] & n[33:17])
		end
	end

	// Note an expected state; full mask unless only the low byte matters
	task automatic chk(input logic [7:0] lo, input logic [7:0] hi, input logic fl, input bit lo_only);
		exp_q.push_back({(lo_only ? 17'h000FF : 17'h1FFFF), fl, hi, lo});
		chk_req <= 1'b1;
		@(posedge sys_clk_i);
		chk_req <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	// One-cycle software strobe: 0 high write, 1 low write, 2 low read, 3 flag clear
	task automatic sw(input int which, input logic [7:0] d);
		case (which)
			0: high_byte_wr_i <= 1'b1;
			1: low_byte_wr_i <= 1'b1;
			2: low_byte_rd_i <= 1'b1;
			default: overflow_clr_i <= 1'b1;
		endcase
		wr_data_i <= d;
		@(posedge sys_clk_i);
		{high_byte_wr_i, low_byte_wr_i, low_byte_rd_i, overflow_clr_i} <= 4'h0;
		@(posedge sys_clk_i); // Gap so back-to-back strobes never collide
	endtask

	// Pulse one source n times, low cycle between edges, then let the count land
	task automatic pulse(input int idx, input int n);
		repeat (n)
		begin
			src_lvl[idx] <= 1'b1;
			@(posedge sys_clk_i);
			src_lvl[idx] <= 1'b0;
			@(posedge sys_clk_i);
		end
		repeat (3) @(posedge sys_clk_i);
	endtask

	// Single place where the run ends
	task automatic test_done;
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog at 20000 cycles; whole sequence needs well under 2000 cycles
	initial
	begin
		#(20000 * 4);
		err_total++;
		test_done();
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'hB4C78D2C));
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		chk(8'h00, 8'hFF, 1'b0, 0);
		// 8-bit period match with period 3
		sw(0, 8'h03);
		sw(1, 8'hFF);
		pulse(0, 1);
		chk(8'h00, 8'h03, 1'b1, 0);
		sw(3, 8'h00);
		pulse(0, 3);
		chk(8'h03, 8'h03, 1'b0, 0);
		pulse(0, 1);
		chk(8'h00, 8'h03, 1'b1, 0);
		// Clear lands in the very cycle of a match: the set must win
		sw(3, 8'h00);
		pulse(0, 3);
		src_lvl[0] <= 1'b1;
		@(posedge sys_clk_i);
		src_lvl[0] <= 1'b0;
		overflow_clr_i <= 1'b1;
		@(posedge sys_clk_i);
		overflow_clr_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk(8'h00, 8'h03, 1'b1, 0);
		// 16-bit: buffered writes, latched reads, wrap
		width_sel <= 1'b1;
		sw(3, 8'h00);
		sw(0, 8'h12);
		sw(1, 8'hFE);
		pulse(0, 1);
		sw(2, 8'h00);
		chk(8'hFF, 8'h12, 1'b0, 0);
		pulse(0, 1);
		sw(2, 8'h00);
		chk(8'h00, 8'h13, 1'b0, 0);
		sw(0, 8'hFF);
		sw(1, 8'hFF);
		pulse(0, 1);
		sw(2, 8'h00);
		chk(8'h00, 8'h00, 1'b1, 0);
		// High write alone must not reach the running count
		sw(0, 8'h55);
		pulse(0, 1);
		sw(2, 8'h00);
		chk(8'h01, 8'h00, 1'b1, 0);
		sw(3, 8'h00);
		// Prescaler: k counts need k*2^n edges; extra 2^n-1 edges add none
		for (int n = 0; n < 4; n++)
		begin
			cs_sel <= 3'h0; // Reserved code clears the prescaler
			ps_sel <= n[3:0];
			repeat (2) @(posedge sys_clk_i);
			cs_sel <= BT_CS_INSTR_CLK;
			k = 1 + $urandom_range(2);
			sw(1, 8'h00);
			pulse(0, (k << n) + (1 << n) - 1);
			chk(k[7:0], 8'h00, 1'b0, 1);
		end
		// Every source code counts its own source, not the next code's (7 wraps to 2)
		ps_sel <= 4'h0;
		for (int c = 7; c >= 2; c--)
		begin
			cs_sel <= c[2:0];
			sw(1, 8'h00);
			pulse(c - 2, 2);
			pulse((c - 1) % 6, 1);
			chk(8'h02, 8'h00, 1'b0, 1);
		end
		// Reserved codes hold the count against every source
		for (int c = 0; c < 2; c++)
		begin
			cs_sel <= c[2:0];
			sw(1, 8'h07);
			for (int i = 0; i < 6; i++)
				pulse(i, 1);
			chk(8'h07, 8'h00, 1'b0, 1);
		end
		// Sync mode: tick waits for the instruction clock edge
		cs_sel <= BT_CS_SECONDARY;
		async_sel <= 1'b0;
		sw(1, 8'h00);
		pulse(4, 1);
		chk(8'h00, 8'h00, 1'b0, 1);
		pulse(0, 1);
		chk(8'h01, 8'h00, 1'b0, 1);
		repeat (2) @(posedge sys_clk_i);
		test_done();
	end
endmodule // testbench
`default_nettype wire
